/* bus_cycle_pkg.sv */
// constants for the multiplexed bus-cycle engine
// assumes a single 20 MHz clock domain and an active-low asynchronous reset
package bus_cycle_pkg;

    // bus states, one per clock
    typedef enum logic [2:0] {
        IDLE_ST  = 3'b000,
        ADDR_ST  = 3'b001,
        SECOND_ST = 3'b010,
        THIRD_ST = 3'b011,
        WAIT_ST  = 3'b100,
        FINAL_ST = 3'b101,
        HOLD_ST  = 3'b110
    } bus_state_type;

    // cycle kinds requested by the core
    typedef enum logic [1:0] {
        KIND_READ  = 2'b00,
        KIND_WRITE = 2'b01,
        KIND_IACK  = 2'b10
    } cycle_kind_type;

    // segment codes carried on the two low status bits (high, low)
    localparam logic [1:0] SEG_ALT_DATA = 2'b00;
    localparam logic [1:0] SEG_STACK    = 2'b01;
    localparam logic [1:0] SEG_CODE     = 2'b10;
    localparam logic [1:0] SEG_DATA     = 2'b11;

    // reset values of the address/data and upper lines, and the acknowledge cycle count
    localparam logic [15:0] ADDR_DATA_RESET = 16'h0000;
    localparam logic [3:0]  UPPER_RESET     = 4'h0;
    localparam logic [1:0]  IACK_CYCLES     = 2'h2;

endpackage : bus_cycle_pkg

/* cpu_muxed_bus_cycle_interface.sv */
// multiplexed address/data bus cycle engine of a 16-bit processor
// assumes the core issues one request at a time and holds it until done pulses
`timescale 1ns/10ps
`default_nettype none

module cpu_muxed_bus_cycle_interface (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    // request from the core
    input  wire logic                           reqValid,
    input  wire bus_cycle_pkg::cycle_kind_type  reqKind,
    input  wire logic                           reqMemory,
    input  wire logic [19:0]                    reqAddr,
    input  wire logic                           reqHighByte,
    input  wire logic                           reqLowByte,
    input  wire logic [15:0]                    reqWriteData,
    input  wire logic [1:0]                     reqSegment,
    input  wire logic                           reqIntEnable,
    // answer to the core
    output logic                                reqDone,
    output logic [15:0]                         readData,
    // shared address/data lines
    input  wire logic [15:0]                    sharedAddrDataIn,
    output logic [15:0]                         sharedAddrDataOut,
    output logic                                sharedAddrDataOe,
    // upper address/status lines and high byte line
    output logic [3:0]                          upperAddrStatus,
    output logic                                upperAddrStatusOe,
    output logic                                highByteLaneEnableStatus,
    output logic                                highByteOe,
    // strobes and control
    output logic                                readStrobe_n,
    output logic                                writeStrobe_n,
    output logic                                strobeOe,
    output logic                                irqAckStrobe_n,
    output logic                                addrLatchEnable,
    output logic                                memIoSelect,
    // handshake pins
    input  wire logic                           readyIn,
    input  wire logic                           holdRequest,
    output logic                                busGrantOut
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change counts when stages 2 and 3 agree
    logic [2:0] readySync_reg;
    logic [2:0] holdSync_reg;
    logic       readyLevel_reg;
    logic       holdLevel_reg;
    wire  logic readyLevel_next = (readySync_reg[1] == readySync_reg[2]) ? readySync_reg[2] : readyLevel_reg;
    wire  logic holdLevel_next  = (holdSync_reg[1] == holdSync_reg[2]) ? holdSync_reg[2] : holdLevel_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readySync_reg  <= 3'h0;
            holdSync_reg   <= 3'h0;
            readyLevel_reg <= 1'b0;
            holdLevel_reg  <= 1'b0;
        end else begin
            readySync_reg  <= {readySync_reg[1:0], readyIn};
            holdSync_reg   <= {holdSync_reg[1:0], holdRequest};
            readyLevel_reg <= readyLevel_next;
            holdLevel_reg  <= holdLevel_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state sequencing
    bus_cycle_pkg::bus_state_type state_reg;
    bus_cycle_pkg::bus_state_type state_next;
    logic                         iackSecond_reg;   // second acknowledge cycle in progress
    logic                         iackSecond_next;
    logic                         isIack;
    logic                         isRead;
    logic                         isWrite;

    assign isIack  = (reqKind == bus_cycle_pkg::KIND_IACK);
    assign isRead  = (reqKind == bus_cycle_pkg::KIND_READ);
    assign isWrite = (reqKind == bus_cycle_pkg::KIND_WRITE);

    // hold only granted between cycles, so a started cycle always completes
    always_comb begin
        state_next      = state_reg;
        iackSecond_next = iackSecond_reg;
        unique case (state_reg)
            bus_cycle_pkg::IDLE_ST: begin
                if (holdLevel_reg)
                    state_next = bus_cycle_pkg::HOLD_ST;
                // the core still shows the finished request while done stands, so it is not taken twice
                else if (reqValid && !reqDone)
                    state_next = bus_cycle_pkg::ADDR_ST;
            end
            bus_cycle_pkg::ADDR_ST:   state_next = bus_cycle_pkg::SECOND_ST;
            bus_cycle_pkg::SECOND_ST: state_next = bus_cycle_pkg::THIRD_ST;
            bus_cycle_pkg::THIRD_ST,
            bus_cycle_pkg::WAIT_ST:
                state_next = readyLevel_reg ? bus_cycle_pkg::FINAL_ST : bus_cycle_pkg::WAIT_ST;
            bus_cycle_pkg::FINAL_ST: begin
                if (isIack && !iackSecond_reg) begin
                    state_next      = bus_cycle_pkg::ADDR_ST;
                    iackSecond_next = 1'b1;
                end else begin
                    state_next      = bus_cycle_pkg::IDLE_ST;
                    iackSecond_next = 1'b0;
                end
            end
            bus_cycle_pkg::HOLD_ST:
                if (!holdLevel_reg)
                    state_next = bus_cycle_pkg::IDLE_ST;
            default: state_next = bus_cycle_pkg::IDLE_ST;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= bus_cycle_pkg::IDLE_ST;
            iackSecond_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            iackSecond_reg <= iackSecond_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin values decoded from the next state, so every pin is a flip-flop
    wire logic nAddr  = (state_next == bus_cycle_pkg::ADDR_ST);
    wire logic nData  = (state_next == bus_cycle_pkg::SECOND_ST) || (state_next == bus_cycle_pkg::THIRD_ST)
                      || (state_next == bus_cycle_pkg::WAIT_ST) || (state_next == bus_cycle_pkg::FINAL_ST);
    wire logic nHold  = (state_next == bus_cycle_pkg::HOLD_ST);
    wire logic nFinal = (state_next == bus_cycle_pkg::FINAL_ST);
    wire logic inCyc  = nAddr || nData;
    // read strobe window starts a state after the address floats
    wire logic nReadWin = (state_next == bus_cycle_pkg::THIRD_ST) || (state_next == bus_cycle_pkg::WAIT_ST);

    // address in addr phase, write data later, float for reads and acknowledge
    wire logic [15:0] sharedOut_next = nAddr ? {reqAddr[15:1], ~reqLowByte} : reqWriteData;
    wire logic        sharedOe_next  = !isIack && (nAddr || (nData && isWrite));
    // upper address in addr phase, I/O forces zero, then status
    // acknowledge cycles select I/O space, so their upper lines stay low like an I/O cycle
    wire logic [3:0]  upper_next = nAddr ? ((reqMemory && !isIack) ? reqAddr[19:16] : 4'h0)
                                         : {1'b0, reqIntEnable, reqSegment[1], reqSegment[0]};
    // lane enable (active low) then status
    wire logic        highByte_next = nAddr ? ~reqHighByte : 1'b0;
    // strobes in data states, released in final state
    // one turnaround state with nobody driving before the read strobe
    wire logic        rdStrobe_next = !(nReadWin && isRead);
    wire logic        wrStrobe_next = !(nData && !nFinal && isWrite);
    wire logic        iackStrobe_next = !(nData && !nFinal && isIack);
    wire logic        ioSelect_next = isIack ? 1'b0 : reqMemory;
    wire logic        done_next = (state_reg == bus_cycle_pkg::FINAL_ST) && (!isIack || iackSecond_reg);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sharedAddrDataOut        <= bus_cycle_pkg::ADDR_DATA_RESET;
            sharedAddrDataOe         <= 1'b0;
            upperAddrStatus          <= bus_cycle_pkg::UPPER_RESET;
            upperAddrStatusOe        <= 1'b0;
            highByteLaneEnableStatus <= 1'b1;
            highByteOe               <= 1'b0;
            readStrobe_n             <= 1'b1;
            writeStrobe_n            <= 1'b1;
            strobeOe                 <= 1'b0;
            irqAckStrobe_n           <= 1'b1;
            addrLatchEnable          <= 1'b0;
            memIoSelect              <= 1'b0;
            busGrantOut              <= 1'b0;
            reqDone                  <= 1'b0;
            readData                 <= bus_cycle_pkg::ADDR_DATA_RESET;
        end else begin
            sharedAddrDataOut        <= sharedOut_next;
            sharedAddrDataOe         <= sharedOe_next;
            upperAddrStatus          <= upper_next;
            upperAddrStatusOe        <= !nHold && inCyc;
            highByteLaneEnableStatus <= highByte_next;
            highByteOe               <= !nHold && inCyc;
            readStrobe_n             <= rdStrobe_next;
            writeStrobe_n            <= wrStrobe_next;
            // strobes and select float in hold
            strobeOe                 <= !nHold;
            irqAckStrobe_n           <= iackStrobe_next;
            // one clock pulse per address phase
            addrLatchEnable          <= nAddr;
            memIoSelect              <= ioSelect_next;
            busGrantOut              <= nHold;
            reqDone                  <= done_next;
            // read data captured at end of the last ready-qualified state
            if (state_reg != bus_cycle_pkg::IDLE_ST && state_next == bus_cycle_pkg::FINAL_ST && isRead)
                readData <= sharedAddrDataIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // read strobe never active while we drive the shared lines
    rd_no_drive_a: assert property (
        @(posedge clk) disable iff (!reset_n) !readStrobe_n |-> !sharedAddrDataOe)
        else $error("bus driven during read");
    // shared lines already released in the clock before the read strobe
    rd_turn_a: assert property (
        @(posedge clk) disable iff (!reset_n) !readStrobe_n |-> !$past(sharedAddrDataOe))
        else $error("no turnaround before read");
    ale_pulse_a: assert property (
        @(posedge clk) disable iff (!reset_n) addrLatchEnable |=> !addrLatchEnable)
        else $error("ale wider than one clock");
    hold_float_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        busGrantOut |-> !sharedAddrDataOe && !strobeOe && !upperAddrStatusOe)
        else $error("driving during hold");
    // address phase is followed by second state
    addr_step_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_reg == bus_cycle_pkg::ADDR_ST |=> state_reg == bus_cycle_pkg::SECOND_ST)
        else $error("bad state step");
    // no ready in third state means a wait
    wait_ins_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_reg == bus_cycle_pkg::THIRD_ST && !readyLevel_reg) |=> state_reg == bus_cycle_pkg::WAIT_ST)
        else $error("wait not inserted");
    // I/O address phase drives upper lines low
    io_upper_a: assert property (
        @(posedge clk) disable iff (!reset_n) (addrLatchEnable && !memIoSelect) |-> upperAddrStatus == 4'h0)
        else $error("upper lines not low for io");
    final_idle_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_reg == bus_cycle_pkg::FINAL_ST |-> readStrobe_n && writeStrobe_n)
        else $error("strobe active in final state");
    // acknowledge cycles never drive the shared lines
    iack_float_a: assert property (
        @(posedge clk) disable iff (!reset_n) !irqAckStrobe_n |-> !sharedAddrDataOe ##1 !sharedAddrDataOe)
        else $error("bus driven in acknowledge");
    // hold request seen while idle is granted at the next clock
    hold_grant_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (holdLevel_reg && state_reg == bus_cycle_pkg::IDLE_ST) |=> busGrantOut)
        else $error("hold not granted");

endmodule : cpu_muxed_bus_cycle_interface

`default_nettype wire

/* bus_partner_model.sv */
// far-side model: memory or i/o device answering the bus strobes
// assumes active-low strobes and an address valid while ALE is high
`timescale 1ns/10ps
`default_nettype none
module bus_partner_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // bus as seen from the far end
    input  wire logic        addrLatchEnable,
    input  wire logic [15:0] sharedAddrDataOut,
    input  wire logic        readStrobe_n,
    input  wire logic        writeStrobe_n,
    input  wire logic        irqAckStrobe_n,
    input  wire logic [3:0]  waitCount,
    output logic [15:0]      sharedAddrDataIn,
    output logic             readyIn
);
    logic [15:0] latched_reg;
    logic [3:0]  count_reg;
    logic        strobeActive;
    ////////////////////////////////////////////////////////////////
    // any strobe low means a transfer is open
    assign strobeActive = !readStrobe_n || !writeStrobe_n || !irqAckStrobe_n;
    assign readyIn = strobeActive && (count_reg >= waitCount);
    // data flips every clock when neither read nor acknowledge strobe is low, so a stale bus never matches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latched_reg <= 16'h0000;
            count_reg <= 4'h0;
            sharedAddrDataIn <= 16'h0000;
        end else begin
            if (addrLatchEnable)
                latched_reg <= sharedAddrDataOut;
            count_reg <= strobeActive ? count_reg + ((count_reg == 4'hf) ? 4'h0 : 4'h1) : 4'h0;
            // value held steady under the acknowledge strobe, as a cascade code would be
            if (!readStrobe_n)
                sharedAddrDataIn <= latched_reg ^ 16'h5a3c;
            else if (irqAckStrobe_n)
                sharedAddrDataIn <= ~sharedAddrDataIn;
        end
    end
endmodule : bus_partner_model
`default_nettype wire

/* cpu_muxed_bus_cycle_interface_test.sv */
// self-checking bench for the multiplexed bus-cycle engine
// assumes bus_partner_model answers strobes; one request at a time
`timescale 1ns/10ps
`default_nettype none
module cpu_muxed_bus_cycle_interface_test;
    logic        clk, reset_n, reqValid, reqMemory, reqHighByte, reqLowByte, reqIntEnable, holdRequest;
    logic        reqDone, sharedAddrDataOe, upperAddrStatusOe, highByteOe, highByteLaneEnableStatus;
    logic        readStrobe_n, writeStrobe_n, strobeOe, irqAckStrobe_n, addrLatchEnable, memIoSelect;
    logic        readyIn, busGrantOut;
    logic [1:0]  reqSegment;
    logic [3:0]  upperAddrStatus, waitCount;
    logic [15:0] reqWriteData, readData, sharedAddrDataIn, sharedAddrDataOut;
    logic [19:0] reqAddr;
    bus_cycle_pkg::cycle_kind_type reqKind;
    int          nErrors, checked;
    ////////////////////////////////////////////////////////////////
    cpu_muxed_bus_cycle_interface i_dut (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
        .reqKind(reqKind), .reqMemory(reqMemory), .reqAddr(reqAddr), .reqHighByte(reqHighByte),
        .reqLowByte(reqLowByte), .reqWriteData(reqWriteData), .reqSegment(reqSegment),
        .reqIntEnable(reqIntEnable), .reqDone(reqDone), .readData(readData),
        .sharedAddrDataIn(sharedAddrDataIn), .sharedAddrDataOut(sharedAddrDataOut),
        .sharedAddrDataOe(sharedAddrDataOe), .upperAddrStatus(upperAddrStatus),
        .upperAddrStatusOe(upperAddrStatusOe), .highByteLaneEnableStatus(highByteLaneEnableStatus),
        .highByteOe(highByteOe), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .strobeOe(strobeOe), .irqAckStrobe_n(irqAckStrobe_n), .addrLatchEnable(addrLatchEnable),
        .memIoSelect(memIoSelect), .readyIn(readyIn), .holdRequest(holdRequest), .busGrantOut(busGrantOut));
    bus_partner_model i_partner (.clk(clk), .reset_n(reset_n), .addrLatchEnable(addrLatchEnable),
        .sharedAddrDataOut(sharedAddrDataOut), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .irqAckStrobe_n(irqAckStrobe_n), .waitCount(waitCount), .sharedAddrDataIn(sharedAddrDataIn),
        .readyIn(readyIn));
    ////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // read data the partner returns for a latched address word
    function automatic logic [15:0] exp_read(input logic [19:0] a, input logic lo);
        return {a[15:1], ~lo} ^ 16'h5a3c;
    endfunction : exp_read
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // one bus cycle, watched each clock at the falling edge
    task automatic do_cycle(input logic [1:0] kind, input logic mem, input logic [19:0] a,
                            input logic [1:0] seg, input logic [3:0] w);
        logic hi, lo, ie, prevOe, prevAck;
        logic [15:0] wd;
        int n, aleAt, rdAt, acks;
        hi = 1'($urandom);
        lo = !hi | 1'($urandom);
        ie = 1'($urandom);
        wd = 16'($urandom);
        n = 0; aleAt = 0; rdAt = 0; acks = 0; prevOe = 1'b0; prevAck = 1'b0;
        @(posedge clk);
        reqValid <= 1'b1; reqKind <= bus_cycle_pkg::cycle_kind_type'(kind); reqMemory <= mem;
        reqAddr <= a; reqHighByte <= hi; reqLowByte <= lo; reqWriteData <= wd;
        reqSegment <= seg; reqIntEnable <= ie; waitCount <= w;
        do begin
            @(negedge clk);
            n++;
            if (addrLatchEnable === 1'b1 && kind != 2'd2) begin
                aleAt = n;
                check(sharedAddrDataOut, {a[15:1], ~lo});
                check(upperAddrStatus, mem ? a[19:16] : 4'h0);
                check({highByteLaneEnableStatus, memIoSelect}, {~hi, mem});
            end
            if (kind == 2'd2) check(sharedAddrDataOe, 1'b0);
            if (readStrobe_n === 1'b0) begin
                if (rdAt == 0) rdAt = n;
                check({prevOe, sharedAddrDataOe, kind}, 4'h0);
                check(upperAddrStatus, {1'b0, ie, seg});
            end
            if (writeStrobe_n === 1'b0) begin
                check({sharedAddrDataOe, sharedAddrDataOut}, {1'b1, wd});
                check(upperAddrStatus, {1'b0, ie, seg});
            end
            if (irqAckStrobe_n === 1'b0 && !prevAck) acks++;
            prevAck = (irqAckStrobe_n === 1'b0);
            prevOe = sharedAddrDataOe;
        end while (reqDone !== 1'b1 && n < 300);
        check(reqDone, 1'b1);
        check(n >= 5 + w, 1'b1);
        if (kind == 2'd0) check({readData, rdAt > aleAt && aleAt > 0}, {exp_read(a, lo), 1'b1});
        if (kind == 2'd2) check(20'(acks), 20'd2);
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk) check({addrLatchEnable, reqDone}, 2'b00);
    endtask : do_cycle
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog far beyond the few hundred clocks the tests need
    initial begin
        #2000000;
        nErrors++;
        give_verdict();
    end
    // corner cases first, then random traffic
    initial begin
        int k;
        reset_n = 1'b0; reqValid = 1'b0; reqKind = bus_cycle_pkg::KIND_READ; reqMemory = 1'b1;
        reqAddr = 20'h00000; reqHighByte = 1'b1; reqLowByte = 1'b1; reqWriteData = 16'h0000;
        reqSegment = 2'h0; reqIntEnable = 1'b0; holdRequest = 1'b0; waitCount = 4'h0;
        nErrors = 0; checked = 0;
        void'($urandom(36147));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int s = 0; s < 4; s++) do_cycle(2'd0, 1'b1, 20'hfffff, 2'(s), 4'(2 * s));
        do_cycle(2'd1, 1'b0, 20'hfffff, 2'd3, 4'd0);
        do_cycle(2'd0, 1'b0, 20'hf0001, 2'd1, 4'd7);
        do_cycle(2'd2, 1'b1, 20'h12345, 2'd2, 4'd1);
        // hold: bus released, pending request kept waiting
        @(posedge clk);
        holdRequest <= 1'b1;
        for (k = 0; k < 20 && busGrantOut !== 1'b1; k++) @(negedge clk);
        check(busGrantOut, 1'b1);
        check({sharedAddrDataOe, upperAddrStatusOe, highByteOe, strobeOe}, 4'h0);
        @(posedge clk);
        reqValid <= 1'b1;
        repeat (4) @(negedge clk) check({addrLatchEnable, busGrantOut}, 2'b01);
        @(posedge clk);
        holdRequest <= 1'b0;
        reqValid <= 1'b0;
        for (int i = 0; i < 20; i++)
            do_cycle(2'($urandom_range(1, 0)), 1'($urandom), 20'($urandom), 2'($urandom), 4'($urandom_range(5, 0)));
        give_verdict();
    end
endmodule : cpu_muxed_bus_cycle_interface_test
`default_nettype wire
